//--- pkg/mmcr_pkg.sv
package mmcr_pkg;

    typedef enum logic [2:0] {
        MMCR_SEL_NONE,
        MMCR_SEL_CFG,
        MMCR_SEL_PULLUP0,
        MMCR_SEL_PULLUP1,
        MMCR_SEL_PULLUP2,
        MMCR_SEL_PULLUP3,
        MMCR_SEL_INTDLY
    } mmcr_reg_sel_t;

    typedef enum logic {
        MMCR_DLY_IDLE,
        MMCR_DLY_TIMING
    } mmcr_dly_state_t;

endpackage

//--- pkg/mmcr_regs.svh
`ifndef MMCR_REGS_SVH
`define MMCR_REGS_SVH

// register offsets in external data space, byte wide
`define MMCR_OFS_CFG         16'hFF90
`define MMCR_OFS_PULLUP0     16'hFF91
`define MMCR_OFS_PULLUP1     16'hFF92
`define MMCR_OFS_PULLUP2     16'hFF93
`define MMCR_OFS_PULLUP3     16'hFF94
`define MMCR_OFS_INTDLY      16'hFF95

// configuration register fields
`define MMCR_CFG_SWITCH_BIT  0
`define MMCR_CFG_REV_LSB     1
`define MMCR_CFG_REV_MSB     4
`define MMCR_CFG_OVC_BIT     5
`define MMCR_CFG_XSEL_BIT    6
`define MMCR_CFG_RSV_BIT     7

// reset values
`define MMCR_RST_PULLUP      8'h00
`define MMCR_RST_INTDLY      4'h2

// memory map
`define MMCR_ROM_SIZE        16'h1800
`define MMCR_ROM_HI_BASE     16'h8000
`define MMCR_RAM_SIZE        16'h2000

// timing
`define MMCR_MS_TIME_NS      1000000
`define MMCR_CLK_PERIOD_NS   100

`endif

//--- rtl/mmcr_ms_delay.sv
`timescale 1ns/1ns
`include "mmcr_regs.svh"

// holds a level change back until it has stood through the programmed number of ms ticks, between delay-1 and delay ms
module mmcr_ms_delay #(
    parameter int DLY_W = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             func_reset,
    input  wire logic             ms_tick,
    input  wire logic [DLY_W-1:0] delay_ms,
    input  wire logic             level_in,
    output logic                  level_out
);

    mmcr_pkg::mmcr_dly_state_t state_r;
    mmcr_pkg::mmcr_dly_state_t state_nxt;
    logic [DLY_W-1:0]          cnt_r;
    logic [DLY_W-1:0]          cnt_nxt;
    logic                      held_r;
    logic                      held_nxt;
    wire                       differs = level_in != held_r;
    wire                       zero_dly = delay_ms == '0;
    wire                       expired = ms_tick && (cnt_r + 1'b1 >= delay_ms);

    // zero delay bypasses the hold so the change reaches the core at once
    assign level_out = zero_dly ? level_in : held_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        held_nxt  = held_r;
        case (state_r)
            mmcr_pkg::MMCR_DLY_IDLE: begin
                cnt_nxt = '0;
                if (differs && zero_dly) begin
                    held_nxt = level_in;
                end else if (differs) begin
                    state_nxt = mmcr_pkg::MMCR_DLY_TIMING;
                end
            end
            mmcr_pkg::MMCR_DLY_TIMING: begin
                // a glitch that falls back restarts the wait
                if (!differs) begin
                    state_nxt = mmcr_pkg::MMCR_DLY_IDLE;
                end else if (zero_dly || expired) begin
                    held_nxt  = level_in;
                    state_nxt = mmcr_pkg::MMCR_DLY_IDLE;
                end else if (ms_tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = mmcr_pkg::MMCR_DLY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= mmcr_pkg::MMCR_DLY_IDLE;
            cnt_r   <= '0;
            held_r  <= 1'b0;
        end else if (func_reset) begin
            state_r <= mmcr_pkg::MMCR_DLY_IDLE;
            cnt_r   <= '0;
            held_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            held_r  <= held_nxt;
        end
    end

endmodule

//--- rtl/mmcr_top.sv
`timescale 1ns/1ns
`include "mmcr_regs.svh"

module mmcr_top #(
    parameter logic [3:0] REVISION     = 4'h5,
    parameter int         PORT_W       = 8,
    parameter int         CYCLES_PER_MS = (`MMCR_MS_TIME_NS + `MMCR_CLK_PERIOD_NS - 1) / `MMCR_CLK_PERIOD_NS
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              func_reset,
    input  wire logic [15:0]       code_addr,
    input  wire logic              code_wr,
    output logic                   code_rom_hit,
    output logic                   code_ram_hit,
    output logic [15:0]            code_mem_addr,
    output logic                   code_wr_blocked,
    input  wire logic [15:0]       external_data_space_addr,
    input  wire logic              external_data_space_wr,
    input  wire logic              external_data_space_rd,
    input  wire logic [7:0]        external_data_space_wdata,
    output logic [7:0]             external_data_space_rdata,
    output logic                   external_data_space_reg_hit,
    output logic                   external_data_space_ram_hit,
    output logic                   ram_we,
    output logic [15:0]            ram_addr,
    output logic                   boot_map_switch,
    output logic                   overcurrent_detect_enable,
    input  wire logic              port3_bit3_pin,
    input  wire logic [PORT_W-1:0] port2_in,
    output logic                   external_interrupt_one,
    output logic [PORT_W-1:0]      pullup_off_port0,
    output logic [PORT_W-1:0]      pullup_off_port1,
    output logic [PORT_W-1:0]      pullup_off_port2,
    output logic [PORT_W-1:0]      pullup_off_port3
);

    localparam int NPORT = 4;

    generate
        if (CYCLES_PER_MS < 1) begin : g_bad_ms
            $error("CYCLES_PER_MS must be at least one");
        end
        if (PORT_W < 1 || PORT_W > 8) begin : g_bad_port
            $error("PORT_W must lie between 1 and 8");
        end
    endgenerate

    // register state
    logic                  boot_map_switch_r;
    logic                  overcurrent_detect_enable_r;
    logic                  ext_irq1_source_select_r;
    logic                  cfg_rsv_r;
    logic [3:0]            interrupt_delay_config_r;
    logic [PORT_W-1:0]     gpio_pullup_port_r [NPORT];
    logic [7:0]            rdata_r;
    logic [7:0]            rdata_nxt;

    // address decode
    mmcr_pkg::mmcr_reg_sel_t reg_sel;

    wire sel_cfg    = external_data_space_addr == `MMCR_OFS_CFG;
    wire sel_pu0    = external_data_space_addr == `MMCR_OFS_PULLUP0;
    wire sel_pu1    = external_data_space_addr == `MMCR_OFS_PULLUP1;
    wire sel_pu2    = external_data_space_addr == `MMCR_OFS_PULLUP2;
    wire sel_pu3    = external_data_space_addr == `MMCR_OFS_PULLUP3;
    wire sel_intdly = external_data_space_addr == `MMCR_OFS_INTDLY;

    assign reg_sel = sel_cfg    ? mmcr_pkg::MMCR_SEL_CFG :
                     sel_pu0    ? mmcr_pkg::MMCR_SEL_PULLUP0 :
                     sel_pu1    ? mmcr_pkg::MMCR_SEL_PULLUP1 :
                     sel_pu2    ? mmcr_pkg::MMCR_SEL_PULLUP2 :
                     sel_pu3    ? mmcr_pkg::MMCR_SEL_PULLUP3 :
                     sel_intdly ? mmcr_pkg::MMCR_SEL_INTDLY :
                                  mmcr_pkg::MMCR_SEL_NONE;

    assign external_data_space_reg_hit = reg_sel != mmcr_pkg::MMCR_SEL_NONE;

    wire wr_cfg    = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_CFG;
    wire wr_intdly = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_INTDLY;

    wire [NPORT-1:0] wr_pullup;
    assign wr_pullup[0] = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_PULLUP0;
    assign wr_pullup[1] = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_PULLUP1;
    assign wr_pullup[2] = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_PULLUP2;
    assign wr_pullup[3] = external_data_space_wr && reg_sel == mmcr_pkg::MMCR_SEL_PULLUP3;

    // memory map
    wire code_low_rom  = code_addr < `MMCR_ROM_SIZE;
    wire code_high_rom = code_addr >= `MMCR_ROM_HI_BASE &&
                         code_addr < (`MMCR_ROM_HI_BASE + `MMCR_ROM_SIZE);
    wire code_low_ram  = code_addr < `MMCR_RAM_SIZE;
    wire external_data_space_low_ram = external_data_space_addr < `MMCR_RAM_SIZE;

    // boot mode mirrors the ROM low so the reset vector lands in it
    assign code_rom_hit = code_high_rom || (!boot_map_switch_r && code_low_rom);
    assign code_ram_hit = boot_map_switch_r && code_low_ram;

    // both ROM images share one physical offset
    assign code_mem_addr = code_high_rom ? (code_addr - `MMCR_ROM_HI_BASE) : code_addr;

    // code space never accepts a write once RAM holds the program
    assign code_wr_blocked = code_wr && boot_map_switch_r;

    assign external_data_space_ram_hit = !boot_map_switch_r && external_data_space_low_ram && !external_data_space_reg_hit;
    assign ram_we        = external_data_space_ram_hit && external_data_space_wr;
    assign ram_addr      = code_ram_hit ? code_addr : external_data_space_addr;

    // configuration register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_map_switch_r <= 1'b0;
        end else if (func_reset) begin
            boot_map_switch_r <= 1'b0;
        end else if (wr_cfg && external_data_space_wdata[`MMCR_CFG_SWITCH_BIT]) begin
            boot_map_switch_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent_detect_enable_r <= 1'b0;
            ext_irq1_source_select_r    <= 1'b0;
            cfg_rsv_r                   <= 1'b0;
        end else if (func_reset) begin
            overcurrent_detect_enable_r <= 1'b0;
            ext_irq1_source_select_r    <= 1'b0;
            cfg_rsv_r                   <= 1'b0;
        end else if (wr_cfg) begin
            overcurrent_detect_enable_r <= external_data_space_wdata[`MMCR_CFG_OVC_BIT];
            ext_irq1_source_select_r    <= external_data_space_wdata[`MMCR_CFG_XSEL_BIT];
            cfg_rsv_r                   <= external_data_space_wdata[`MMCR_CFG_RSV_BIT];
        end
    end

    // interrupt delay register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_delay_config_r <= `MMCR_RST_INTDLY;
        end else if (func_reset) begin
            interrupt_delay_config_r <= `MMCR_RST_INTDLY;
        end else if (wr_intdly) begin
            interrupt_delay_config_r <= external_data_space_wdata[3:0];
        end
    end

    // pullup registers, one per port
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_pullup
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    gpio_pullup_port_r[gp] <= PORT_W'(`MMCR_RST_PULLUP);
                end else if (func_reset) begin
                    gpio_pullup_port_r[gp] <= PORT_W'(`MMCR_RST_PULLUP);
                end else if (wr_pullup[gp]) begin
                    gpio_pullup_port_r[gp] <= external_data_space_wdata[PORT_W-1:0];
                end
            end
        end
    endgenerate

    // a 1 in the register means the pin's pullup is off
    assign pullup_off_port0 = gpio_pullup_port_r[0];
    assign pullup_off_port1 = gpio_pullup_port_r[1];
    assign pullup_off_port2 = gpio_pullup_port_r[2];
    assign pullup_off_port3 = gpio_pullup_port_r[3];

    // read data
    wire [7:0] cfg_view = {cfg_rsv_r,
                           ext_irq1_source_select_r,
                           overcurrent_detect_enable_r,
                           REVISION,
                           boot_map_switch_r};

    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_sel)
            mmcr_pkg::MMCR_SEL_CFG: begin
                rdata_nxt = cfg_view;
            end
            mmcr_pkg::MMCR_SEL_PULLUP0: begin
                rdata_nxt = 8'(gpio_pullup_port_r[0]);
            end
            mmcr_pkg::MMCR_SEL_PULLUP1: begin
                rdata_nxt = 8'(gpio_pullup_port_r[1]);
            end
            mmcr_pkg::MMCR_SEL_PULLUP2: begin
                rdata_nxt = 8'(gpio_pullup_port_r[2]);
            end
            mmcr_pkg::MMCR_SEL_PULLUP3: begin
                rdata_nxt = 8'(gpio_pullup_port_r[3]);
            end
            mmcr_pkg::MMCR_SEL_INTDLY: begin
                rdata_nxt = {4'h0, interrupt_delay_config_r};
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (external_data_space_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign external_data_space_rdata = rdata_r;

    // millisecond tick
    localparam int MS_W = $clog2(CYCLES_PER_MS + 1);

    logic [MS_W-1:0] ms_cnt_r;
    logic            ms_tick;

    assign ms_tick = ms_cnt_r == MS_W'(CYCLES_PER_MS - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_r <= '0;
        end else if (func_reset || ms_tick) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 1'b1;
        end
    end

    // interrupt source routing
    // the first tick can fall anywhere inside the first ms, so the wait is
    // between delay-1 and delay ms; a free prescaler keeps the logic small
    wire port2_any = |port2_in;
    wire port2_held;

    mmcr_ms_delay #(
        .DLY_W (4)
    ) u_delay (
        .clk        (clk),
        .rst_n      (rst_n),
        .func_reset (func_reset),
        .ms_tick    (ms_tick),
        .delay_ms   (interrupt_delay_config_r),
        .level_in   (port2_any),
        .level_out  (port2_held)
    );

    // the pin path stays raw so it acts like the standard external interrupt
    assign external_interrupt_one = ext_irq1_source_select_r ? port2_held : port3_bit3_pin;

    assign boot_map_switch           = boot_map_switch_r;
    assign overcurrent_detect_enable = overcurrent_detect_enable_r;

endmodule

//--- testbench/mmcr_top_asserts.sv
`timescale 1ns/1ns
`include "mmcr_regs.svh"

// the routing bit is not a port, so it is shadowed here from bus writes
module mmcr_top_asserts #(
    parameter logic [3:0] REVISION = 4'h5,
    parameter int         PORT_W   = 8
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              func_reset,
    input wire logic [15:0]       code_addr,
    input wire logic              code_wr,
    input wire logic              code_rom_hit,
    input wire logic              code_ram_hit,
    input wire logic              code_wr_blocked,
    input wire logic [15:0]       external_data_space_addr,
    input wire logic              external_data_space_wr,
    input wire logic              external_data_space_rd,
    input wire logic [7:0]        external_data_space_wdata,
    input wire logic [7:0]        external_data_space_rdata,
    input wire logic              external_data_space_ram_hit,
    input wire logic              boot_map_switch,
    input wire logic              overcurrent_detect_enable,
    input wire logic              port3_bit3_pin,
    input wire logic              external_interrupt_one,
    input wire logic [PORT_W-1:0] pullup_off_port0
);
    logic xsel_r;
    logic cfg_wr;
    assign cfg_wr = external_data_space_wr && (external_data_space_addr == `MMCR_OFS_CFG);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xsel_r <= 1'b0;
        end else if (func_reset) begin
            xsel_r <= 1'b0;
        end else if (cfg_wr) begin
            xsel_r <= external_data_space_wdata[6];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_switch_sticky: assert property (boot_map_switch && !func_reset |=> boot_map_switch)
        else $error("boot map switch dropped without reset");
    a_switch_set: assert property (cfg_wr && external_data_space_wdata[0] && !func_reset |=> boot_map_switch)
        else $error("boot map switch not set by write");
    a_func_clear: assert property (func_reset |=> !boot_map_switch && !overcurrent_detect_enable && pullup_off_port0 == '0)
        else $error("function reset left state behind");
    a_ovc_write: assert property (cfg_wr && !func_reset |=> overcurrent_detect_enable == $past(external_data_space_wdata[5]))
        else $error("overcurrent enable does not follow write");
    a_rom_boot: assert property (!boot_map_switch && code_addr < 16'h1800 |-> code_rom_hit && !code_ram_hit)
        else $error("boot rom not at zero in boot mode");
    a_ram_code: assert property (boot_map_switch && code_addr < 16'h2000 |-> code_ram_hit && !code_rom_hit)
        else $error("ram not code space in normal mode");
    a_wr_block: assert property (code_wr |-> code_wr_blocked == boot_map_switch)
        else $error("code write blocking wrong");
    a_xram_boot: assert property (external_data_space_addr < 16'h2000 |-> external_data_space_ram_hit == !boot_map_switch)
        else $error("ram data window wrong");
    a_int_pin: assert property (!xsel_r |-> external_interrupt_one == port3_bit3_pin)
        else $error("interrupt not from pin");
    a_rev_ro: assert property (external_data_space_rd && external_data_space_addr == `MMCR_OFS_CFG |=> external_data_space_rdata[4:1] == REVISION)
        else $error("revision field wrong");
endmodule

//--- testbench/test_mcu_misc_config_registers.sv
`timescale 1ns/1ns
`include "mmcr_regs.svh"

module test_mcu_misc_config_registers;
    localparam logic [3:0] REV = 4'h9;
    logic        clk = 1'b0, rst_n = 1'b0, func_reset = 1'b0, code_wr = 1'b0;
    logic        external_data_space_wr = 1'b0, external_data_space_rd = 1'b0, port3_bit3_pin = 1'b0;
    logic [15:0] code_addr = 16'h0000, external_data_space_addr = 16'h0000, code_mem_addr, ram_addr;
    logic [7:0]  external_data_space_wdata = 8'h00, port2_in = 8'h00, external_data_space_rdata, pu0, pu1, pu2, pu3;
    logic        code_rom_hit, code_ram_hit, code_wr_blocked, external_data_space_reg_hit, external_data_space_ram_hit, ram_we;
    logic        boot_map_switch, overcurrent_detect_enable, external_interrupt_one, hit;
    int          n_mismatch = 0, n_compared = 0;

    always #50 clk = ~clk;

    mmcr_top #(.REVISION(REV), .PORT_W(8), .CYCLES_PER_MS(10)) uut (
        .clk(clk), .rst_n(rst_n), .func_reset(func_reset), .code_addr(code_addr), .code_wr(code_wr),
        .code_rom_hit(code_rom_hit), .code_ram_hit(code_ram_hit), .code_mem_addr(code_mem_addr),
        .code_wr_blocked(code_wr_blocked), .external_data_space_addr(external_data_space_addr), .external_data_space_wr(external_data_space_wr), .external_data_space_rd(external_data_space_rd),
        .external_data_space_wdata(external_data_space_wdata), .external_data_space_rdata(external_data_space_rdata), .external_data_space_reg_hit(external_data_space_reg_hit),
        .external_data_space_ram_hit(external_data_space_ram_hit), .ram_we(ram_we), .ram_addr(ram_addr), .boot_map_switch(boot_map_switch),
        .overcurrent_detect_enable(overcurrent_detect_enable), .port3_bit3_pin(port3_bit3_pin),
        .port2_in(port2_in), .external_interrupt_one(external_interrupt_one), .pullup_off_port0(pu0),
        .pullup_off_port1(pu1), .pullup_off_port2(pu2), .pullup_off_port3(pu3)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        external_data_space_addr  <= a;
        external_data_space_wdata <= d;
        external_data_space_wr    <= 1'b1;
        @(posedge clk);
        external_data_space_wr <= 1'b0;
        #1;
    endtask

    // read data is registered at the taking edge and looked at just after it
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string name);
        @(posedge clk);
        external_data_space_addr <= a;
        external_data_space_rd   <= 1'b1;
        @(posedge clk);
        external_data_space_rd <= 1'b0;
        #1;
        check(name, 16'(external_data_space_rdata), 16'(e));
    endtask

    task automatic setc(input logic [15:0] a, input logic w);
        @(posedge clk);
        code_addr <= a;
        code_wr   <= w;
        #1;
    endtask

    // the ram strobe is combinational, so it is looked at while the write stands
    task automatic wram(input logic [15:0] a, input logic e);
        @(posedge clk);
        external_data_space_addr  <= a;
        external_data_space_wdata <= 8'h3C;
        external_data_space_wr    <= 1'b1;
        #1;
        check("ram we", 16'(ram_we), 16'(e));
        @(posedge clk);
        external_data_space_wr <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        rdc(`MMCR_OFS_CFG, {3'b000, REV, 1'b0}, "cfg reset");
        check("reg hit", 16'(external_data_space_reg_hit), 16'h0001);
        rdc(`MMCR_OFS_PULLUP3, 8'h00, "pullup3 reset");
        rdc(`MMCR_OFS_INTDLY, 8'h02, "intdly reset");
        rdc(16'h1FFF, 8'h00, "ram window read");
        check("xram hit boot", 16'(external_data_space_ram_hit), 16'h0001);
        check("reg hit ram", 16'(external_data_space_reg_hit), 16'h0000);
        check("ram addr data", ram_addr, 16'h1FFF);
        wram(16'h0040, 1'b1);
        setc(16'h0010, 1'b1);
        check("code map low", 16'({code_rom_hit, code_ram_hit, code_wr_blocked}), 16'h0004);
        setc(16'h8010, 1'b0);
        check("rom image", {code_mem_addr[15:1], code_rom_hit}, 16'h0011);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            wr(`MMCR_OFS_PULLUP0 + 16'(i), 8'h5A ^ 8'(i));
        end
        check("pullup pins 0 1", {pu0, pu1}, 16'h5A5B);
        check("pullup pins 2 3", {pu2, pu3}, 16'h5859);
        for (int i = 0; i < 4; i++) begin
            rdc(`MMCR_OFS_PULLUP0 + 16'(i), 8'h5A ^ 8'(i), "pullup read");
        end
        wr(`MMCR_OFS_INTDLY, 8'hFF);
        rdc(`MMCR_OFS_INTDLY, 8'h0F, "intdly upper");
        wr(`MMCR_OFS_CFG, 8'hFE);
        rdc(`MMCR_OFS_CFG, {3'b111, REV, 1'b0}, "cfg write");
        check("ovc on", 16'(overcurrent_detect_enable), 16'h0001);
        wr(`MMCR_OFS_CFG, 8'h00);
        check("ovc off", 16'(overcurrent_detect_enable), 16'h0000);
        rdc(16'hFF80, 8'h00, "unmapped read");
        check("reg hit unmapped", 16'(external_data_space_reg_hit), 16'h0000);
    endtask

    task automatic t_switch();
        wr(`MMCR_OFS_CFG, 8'h01);
        check("switch set", 16'(boot_map_switch), 16'h0001);
        wr(`MMCR_OFS_CFG, 8'h00);
        check("switch held", 16'(boot_map_switch), 16'h0001);
        setc(16'h0010, 1'b1);
        check("code map normal", 16'({code_rom_hit, code_ram_hit, code_wr_blocked}), 16'h0003);
        check("ram addr code", ram_addr, 16'h0010);
        setc(16'h0010, 1'b0);
        rdc(16'h0100, 8'h00, "ram gone from data");
        check("xram hit normal", 16'(external_data_space_ram_hit), 16'h0000);
        wram(16'h0100, 1'b0);
        wr(`MMCR_OFS_PULLUP1, 8'hFF);
        wr(`MMCR_OFS_INTDLY, 8'h07);
        @(posedge clk);
        func_reset <= 1'b1;
        @(posedge clk);
        func_reset <= 1'b0;
        #1;
        check("func reset", {boot_map_switch, pu1}, 16'h0000);
        rdc(`MMCR_OFS_INTDLY, 8'h02, "intdly func reset");
    endtask

    // short pulses must be dropped; a held change passes only after 2 to 3 ms of 10 cycles
    task automatic t_irq();
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            port3_bit3_pin <= 1'(v);
            #1;
            check("pin source", 16'(external_interrupt_one), 16'(v));
        end
        wr(`MMCR_OFS_INTDLY, 8'h00);
        wr(`MMCR_OFS_CFG, 8'h40);
        @(posedge clk);
        port2_in <= 8'h80;
        #1;
        check("or source", 16'(external_interrupt_one), 16'h0001);
        @(posedge clk);
        port2_in <= 8'h00;
        #1;
        check("or source low", 16'(external_interrupt_one), 16'h0000);
        wr(`MMCR_OFS_INTDLY, 8'h03);
        @(posedge clk);
        port2_in <= 8'h04;
        repeat (6) @(posedge clk);
        port2_in <= 8'h00;
        hit = 1'b0;
        repeat (40) begin
            @(posedge clk);
            #1;
            hit = hit | external_interrupt_one;
        end
        check("pulse dropped", 16'(hit), 16'h0000);
        @(posedge clk);
        port2_in <= 8'h10;
        repeat (15) @(posedge clk);
        #1;
        check("delay early", 16'(external_interrupt_one), 16'h0000);
        for (int k = 0; k < 25 && external_interrupt_one !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("delay done", 16'(external_interrupt_one), 16'h0001);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_switch();
        t_irq();
        print_verdict();
    end
endmodule

bind mmcr_top mmcr_top_asserts #(.REVISION(REVISION), .PORT_W(PORT_W)) chk (
    .clk(clk), .rst_n(rst_n), .func_reset(func_reset), .code_addr(code_addr), .code_wr(code_wr),
    .code_rom_hit(code_rom_hit), .code_ram_hit(code_ram_hit), .code_wr_blocked(code_wr_blocked),
    .external_data_space_addr(external_data_space_addr), .external_data_space_wr(external_data_space_wr), .external_data_space_rd(external_data_space_rd), .external_data_space_wdata(external_data_space_wdata),
    .external_data_space_rdata(external_data_space_rdata), .external_data_space_ram_hit(external_data_space_ram_hit), .boot_map_switch(boot_map_switch),
    .overcurrent_detect_enable(overcurrent_detect_enable), .port3_bit3_pin(port3_bit3_pin),
    .external_interrupt_one(external_interrupt_one), .pullup_off_port0(pullup_off_port0)
);
